// ==== hw/rbci_config_loader.sv ====
// Configuration register loader and mode sequencer for the radio
`timescale 1ns/1ps

// What this block does
// R01 - 16-bit word: write flag, 7-bit address
// R02 - Second byte becomes addressed register value
// R03 - Carrier MHz is 2400 plus channel 1..127
// R04 - Top bit of register 0 selects transmit
// R05 - Host holds sleep state 100 ms
// R06 - Config entry after sleep reloads defaults, 120 ms
// R07 - Host pulses chip select low between words
// R08 - Pre-start enabled when delay code nonzero
// R09 - PLL lock 170 us shortened by pre-start
// R10 - Host waits 20 us, adds three bits
// R11 - Format 0x03: auto-insert addresses, 4-byte FIFO
// R12 - Address length 0x02 gives two-byte addressing
// R13 - Local and destination address byte registers
// R14 - Host writes performance override values
// R15 - Register 0x01 holds power and crystal setting
// R16 - Words shift MSB first while selected
// R17 - Standby keeps configuration; sleep needs re-init
// R18 - Reserved address 0x13 keeps its default
module rbci_config_loader #(
    parameter int unsigned RESET_CYCLES = rbci_pkg::CFG_RESET_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ser_clk_i,
    input  wire logic        ser_data_i,
    input  wire logic        chip_select_i,
    input  wire logic        mode_line_i,
    input  wire logic        power_level_line_i,
    output logic [2:0]       op_state_o,
    output logic             cfg_ready_o,
    output logic             cfg_busy_o,
    output logic             tx_select_o,
    output logic [6:0]       channel_number_o,
    output logic             channel_valid_o,
    output logic [11:0]      carrier_mhz_o,
    output logic [7:0]       tx_power_crystal_o,
    output logic             dest_auto_insert_o,
    output logic             sender_auto_insert_o,
    output logic [8:0]       fifo_bytes_o,
    output logic [7:0]       addr_bytes_o,
    output logic [15:0]      local_address_o,
    output logic [15:0]      dest_address_o,
    output logic [7:0]       preamble_o,
    output logic [31:0]      tuning_o,
    output logic             pll_prestart_en_o,
    output logic [12:0]      pll_delay_us_o,
    output logic [7:0]       tx_latency_us_o,
    output logic [7:0]       words_written_o,
    output logic [7:0]       words_refused_o
);

    localparam int unsigned CW = $clog2(RESET_CYCLES + 1);

    rbci_pkg::rbci_state_t state_q;
    rbci_pkg::rbci_state_t state_d;

    logic [2:0]    pins_sync;
    logic          cs_s;
    logic          mode_s;
    logic          pwr_s;
    logic          tog_sync;
    logic          tog_seen_q;
    logic          word_evt;
    logic [15:0]   word_in;
    logic [6:0]    word_addr;
    logic [7:0]    word_data;
    logic          word_wr;
    logic          word_take;
    logic          load_defaults;
    logic          need_init_q;
    logic [CW-1:0] busy_cnt_q;
    logic [7:0]    regs_q [128];

    logic [8:0]    fifo_bytes;
    logic [12:0]   delay_us;
    logic [13:0]   write_us;
    logic [13:0]   net_us;
    logic [13:0]   latency_us;

    rbci_word_if word_link ();

    rbci_shifter u_shifter (
        .ser_clk_i     (ser_clk_i),
        .rst_i         (rst_i),
        .chip_select_i (chip_select_i),
        .ser_data_i    (ser_data_i),
        .word_o        (word_link.link)
    );

    rbci_sync #(.W(3)) u_pin_sync (
        .clk_i (sys_clk_i),
        .rst_i (rst_i),
        .d_i   ({power_level_line_i, mode_line_i, chip_select_i}),
        .q_o   (pins_sync)
    );

    rbci_sync #(.W(1)) u_tog_sync (
        .clk_i (sys_clk_i),
        .rst_i (rst_i),
        .d_i   (word_link.toggle),
        .q_o   (tog_sync)
    );

    assign pwr_s  = pins_sync[2];
    assign mode_s = pins_sync[1];
    assign cs_s   = pins_sync[0];

    // Word only read once its toggle has crossed; it is stable by then
    assign word_in   = word_link.word;
    assign word_addr = word_in[rbci_pkg::ADDR_MSB:rbci_pkg::ADDR_LSB];
    assign word_data = word_in[rbci_pkg::DATA_MSB:0];
    assign word_wr   = word_in[rbci_pkg::WR_FLAG_BIT]; // R01

    // Addresses software must never alter
    function automatic logic is_protected(input logic [6:0] a);
        return (a == rbci_pkg::REG_RSVD_A) || (a == rbci_pkg::REG_RSVD_B);
    endfunction

    // Operating state from the control lines
    always_comb begin
        if (!pwr_s && mode_s) begin
            state_d = rbci_pkg::ST_SLEEP;
        end else if (!pwr_s) begin
            state_d = rbci_pkg::ST_STOP;
        end else if (mode_s) begin
            state_d = rbci_pkg::ST_ACTIVE;
        end else if (cs_s) begin
            state_d = rbci_pkg::ST_CONFIG;
        end else begin
            state_d = rbci_pkg::ST_STANDBY; // R17
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= rbci_pkg::ST_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    // Defaults reload on first configuration entry after sleep
    assign load_defaults = need_init_q
                         && state_d == rbci_pkg::ST_CONFIG
                         && state_q != rbci_pkg::ST_CONFIG; // R06

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            need_init_q <= 1'b1;
        end else if (state_d == rbci_pkg::ST_SLEEP) begin
            need_init_q <= 1'b1; // R17
        end else if (load_defaults) begin
            need_init_q <= 1'b0;
        end
    end

    // Internal reset period; words during it are refused
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_q <= '0;
        end else if (state_d == rbci_pkg::ST_SLEEP) begin
            busy_cnt_q <= '0;
        end else if (load_defaults) begin
            busy_cnt_q <= CW'(RESET_CYCLES); // R06
        end else if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tog_seen_q <= 1'b0;
        end else begin
            tog_seen_q <= tog_sync;
        end
    end

    assign word_evt  = tog_sync ^ tog_seen_q;
    assign word_take = word_evt && word_wr
                     && state_q == rbci_pkg::ST_CONFIG
                     && busy_cnt_q == '0
                     && !need_init_q
                     && !is_protected(word_addr); // R18

    // Register file
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 128; i++) begin
                regs_q[i] <= rbci_pkg::rbci_default(7'(i));
            end
        end else if (load_defaults) begin
            for (int i = 0; i < 128; i++) begin
                regs_q[i] <= rbci_pkg::rbci_default(7'(i)); // R06
            end
        end else if (word_take) begin
            regs_q[word_addr] <= word_data; // R02
        end
    end

    // Write statistics
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            words_written_o <= 8'h00;
            words_refused_o <= 8'h00;
        end else if (load_defaults) begin
            words_written_o <= 8'h00;
            words_refused_o <= 8'h00;
        end else if (word_take) begin
            words_written_o <= words_written_o + 8'h01;
        end else if (word_evt) begin
            words_refused_o <= words_refused_o + 8'h01;
        end
    end

    // Transmit turn-on latency, serial clock taken as one bit per us
    always_comb begin
        fifo_bytes = {1'b0, regs_q[rbci_pkg::REG_PKT_FORMAT]
                               [7:rbci_pkg::FMT_SIZE_LSB], 2'b00}
                   + 9'h004; // R11
        delay_us   = 13'(regs_q[rbci_pkg::REG_PLL_DELAY]
                   * rbci_pkg::PLL_STEP_US); // R08
        write_us   = 14'(rbci_pkg::FIFO_LEAD_US)
                   + 14'({fifo_bytes, 3'b000} * rbci_pkg::SER_BIT_US)
                   + 14'(rbci_pkg::DUMMY_BITS * rbci_pkg::SER_BIT_US);
        if (delay_us != 13'h0000 && write_us > {1'b0, delay_us}) begin
            net_us = write_us - {1'b0, delay_us}; // R09
        end else begin
            net_us = 14'h0000;
        end
        if (net_us >= 14'(rbci_pkg::PLL_LOCK_US)) begin
            latency_us = 14'h0000;
        end else begin
            latency_us = 14'(rbci_pkg::PLL_LOCK_US) - net_us; // R09
        end
    end

    // Registered view of the configuration
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_state_o           <= 3'h0;
            cfg_ready_o          <= 1'b0;
            cfg_busy_o           <= 1'b0;
            tx_select_o          <= 1'b0;
            channel_number_o     <= 7'h00;
            channel_valid_o      <= 1'b0;
            carrier_mhz_o        <= 12'h000;
            tx_power_crystal_o   <= 8'h00;
            dest_auto_insert_o   <= 1'b0;
            sender_auto_insert_o <= 1'b0;
            fifo_bytes_o         <= 9'h000;
            addr_bytes_o         <= 8'h00;
            local_address_o      <= 16'h0000;
            dest_address_o       <= 16'h0000;
            preamble_o           <= 8'h00;
            tuning_o             <= 32'h0000_0000;
            pll_prestart_en_o    <= 1'b0;
            pll_delay_us_o       <= 13'h0000;
            tx_latency_us_o      <= 8'h00;
        end else begin
            op_state_o  <= state_q;
            cfg_busy_o  <= busy_cnt_q != '0;
            cfg_ready_o <= !need_init_q && busy_cnt_q == '0;
            tx_select_o <= regs_q[rbci_pkg::REG_DIR_CHAN]
                                 [rbci_pkg::DIR_TX_BIT]; // R04
            channel_number_o <= regs_q[rbci_pkg::REG_DIR_CHAN][6:0];
            channel_valid_o  <=
                regs_q[rbci_pkg::REG_DIR_CHAN][6:0] != 7'h00; // R03
            carrier_mhz_o <= 12'(rbci_pkg::CHAN_BASE_MHZ)
                + {5'h00, regs_q[rbci_pkg::REG_DIR_CHAN][6:0]}; // R03
            tx_power_crystal_o <= regs_q[rbci_pkg::REG_TX_POWER]; // R15
            dest_auto_insert_o <= regs_q[rbci_pkg::REG_PKT_FORMAT]
                                        [rbci_pkg::FMT_DEST_BIT]; // R11
            sender_auto_insert_o <= regs_q[rbci_pkg::REG_PKT_FORMAT]
                                          [rbci_pkg::FMT_SENDER_BIT];
            fifo_bytes_o    <= fifo_bytes; // R11
            addr_bytes_o    <= regs_q[rbci_pkg::REG_ADDR_LEN]; // R12
            local_address_o <= {regs_q[rbci_pkg::REG_LOCAL_HI],
                                regs_q[rbci_pkg::REG_LOCAL_LO]}; // R13
            dest_address_o  <= {regs_q[rbci_pkg::REG_DEST_HI],
                                regs_q[rbci_pkg::REG_DEST_LO]}; // R13
            preamble_o <= regs_q[rbci_pkg::REG_PREAMBLE];
            tuning_o   <= {regs_q[rbci_pkg::REG_TUNE_D],
                           regs_q[rbci_pkg::REG_TUNE_C],
                           regs_q[rbci_pkg::REG_TUNE_B],
                           regs_q[rbci_pkg::REG_TUNE_A]};
            pll_prestart_en_o <=
                regs_q[rbci_pkg::REG_PLL_DELAY] != 8'h00; // R08
            pll_delay_us_o  <= delay_us;
            tx_latency_us_o <= latency_us[7:0];
        end
    end

endmodule // rbci_config_loader

// ==== hw/rbci_pkg.sv ====
// Constants, field layout and types for the radio configuration loader
package rbci_pkg;

    // Clocking and timing
    localparam int unsigned SYS_CLK_HZ       = 40_000_000;
    localparam int unsigned CFG_RESET_MS     = 120;
    localparam int unsigned CFG_RESET_CYCLES =
        CFG_RESET_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned PLL_LOCK_US      = 170;
    localparam int unsigned PLL_STEP_US      = 20;
    localparam int unsigned FIFO_LEAD_US     = 20;
    localparam int unsigned DUMMY_BITS       = 3;
    localparam int unsigned SER_BIT_US       = 1;
    localparam int unsigned CHAN_BASE_MHZ    = 2400;

    // Configuration word layout
    localparam int unsigned WORD_BITS   = 16;
    localparam int unsigned WR_FLAG_BIT = 15;
    localparam int unsigned ADDR_MSB    = 14;
    localparam int unsigned ADDR_LSB    = 8;
    localparam int unsigned DATA_MSB    = 7;

    // Register offsets
    localparam logic [6:0] REG_DIR_CHAN   = 7'h00;
    localparam logic [6:0] REG_TX_POWER   = 7'h01;
    localparam logic [6:0] REG_PKT_FORMAT = 7'h05;
    localparam logic [6:0] REG_PREAMBLE   = 7'h06;
    localparam logic [6:0] REG_ADDR_LEN   = 7'h08;
    localparam logic [6:0] REG_DEST_LO    = 7'h09;
    localparam logic [6:0] REG_DEST_HI    = 7'h0a;
    localparam logic [6:0] REG_LOCAL_LO   = 7'h0e;
    localparam logic [6:0] REG_LOCAL_HI   = 7'h0f;
    localparam logic [6:0] REG_RSVD_A     = 7'h13;
    localparam logic [6:0] REG_PLL_DELAY  = 7'h14;
    localparam logic [6:0] REG_ANALOG_ON  = 7'h15;
    localparam logic [6:0] REG_RSVD_B     = 7'h16;
    localparam logic [6:0] REG_OPTION     = 7'h17;
    localparam logic [6:0] REG_TUNE_A     = 7'h2c;
    localparam logic [6:0] REG_TUNE_B     = 7'h39;
    localparam logic [6:0] REG_TUNE_C     = 7'h4f;
    localparam logic [6:0] REG_TUNE_D     = 7'h77;

    // Field positions
    localparam int unsigned DIR_TX_BIT     = 7;
    localparam int unsigned FMT_DEST_BIT   = 0;
    localparam int unsigned FMT_SENDER_BIT = 1;
    localparam int unsigned FMT_SIZE_LSB   = 2;

    // Power-on defaults of registers that are not zero
    localparam logic [7:0] DEF_PREAMBLE  = 8'h30;
    localparam logic [7:0] DEF_ANALOG_ON = 8'hb4;
    localparam logic [7:0] DEF_OPTION    = 8'h22;
    localparam logic [7:0] DEF_TUNE_A    = 8'h19;
    localparam logic [7:0] DEF_TUNE_B    = 8'hbb;
    localparam logic [7:0] DEF_TUNE_C    = 8'h26;
    localparam logic [7:0] DEF_TUNE_D    = 8'h7c;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_STOP,
        ST_STANDBY,
        ST_CONFIG,
        ST_ACTIVE
    } rbci_state_t;

    function automatic logic [7:0] rbci_default(input logic [6:0] a);
        unique case (a)
            REG_PREAMBLE:  return DEF_PREAMBLE;
            REG_ANALOG_ON: return DEF_ANALOG_ON;
            REG_OPTION:    return DEF_OPTION;
            REG_TUNE_A:    return DEF_TUNE_A;
            REG_TUNE_B:    return DEF_TUNE_B;
            REG_TUNE_C:    return DEF_TUNE_C;
            REG_TUNE_D:    return DEF_TUNE_D;
            default:       return 8'h00;
        endcase
    endfunction

endpackage

// ==== hw/rbci_word_if.sv ====
// Configuration word handed from the serial clock domain to the core
`timescale 1ns/1ps
interface rbci_word_if;
    logic [15:0] word;
    logic        toggle;
    modport link (output word, output toggle);
    modport core (input word, input toggle);
endinterface

// ==== hw/rbci_sync.sv ====
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rbci_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // rbci_sync

// ==== hw/rbci_shifter.sv ====
// Serial shifter that assembles 16-bit configuration words on the link clock
`timescale 1ns/1ps
module rbci_shifter (
    input  wire logic  ser_clk_i,
    input  wire logic  rst_i,
    input  wire logic  chip_select_i,
    input  wire logic  ser_data_i,
    rbci_word_if.link  word_o
);
    logic [14:0] shift_q;
    logic [3:0]  count_q;
    logic        frame_rst;

    // Frame ends with chip select low; partial words are dropped
    assign frame_rst = rst_i | ~chip_select_i;

    always_ff @(posedge ser_clk_i or posedge frame_rst) begin
        if (frame_rst) begin
            shift_q <= 15'h0000;
            count_q <= 4'h0;
        end else begin
            shift_q <= {shift_q[13:0], ser_data_i}; // R16
            count_q <= count_q + 4'h1;
        end
    end

    // Whole word held until the next one; toggle marks its arrival
    always_ff @(posedge ser_clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_o.word   <= 16'h0000;
            word_o.toggle <= 1'b0;
        end else if (chip_select_i && count_q == 4'hf) begin
            word_o.word   <= {shift_q, ser_data_i}; // R01
            word_o.toggle <= ~word_o.toggle;
        end
    end
endmodule // rbci_shifter

// ==== dv/rbci_config_loader_assertions.sv ====
// Concurrent checks on the configuration loader ports
`timescale 1ns/1ps
module rbci_config_loader_assertions #(
    parameter int unsigned RESET_CYCLES = 20
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  op_state_o,
    input  wire logic        cfg_ready_o,
    input  wire logic        cfg_busy_o,
    input  wire logic [6:0]  channel_number_o,
    input  wire logic        channel_valid_o,
    input  wire logic [11:0] carrier_mhz_o,
    input  wire logic [8:0]  fifo_bytes_o,
    input  wire logic        pll_prestart_en_o,
    input  wire logic [12:0] pll_delay_us_o,
    input  wire logic [7:0]  tx_latency_us_o,
    input  wire logic [7:0]  words_written_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] busy_q;
    logic        live_q;
    int          fill_w;
    int          net_w;
    int          lat_w;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) busy_q <= '0;
        else busy_q <= cfg_busy_o ? busy_q + 1 : '0;
    end
    // Outputs carry the defaults view only from the first edge after reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) live_q <= 1'b0;
        else live_q <= 1'b1;
    end
    // Mode-to-write lead plus dummy bits, one bit per microsecond
    always_comb begin
        fill_w = 23 + 8 * int'(fifo_bytes_o);
        net_w  = (fill_w > int'(pll_delay_us_o)) ?
                 fill_w - int'(pll_delay_us_o) : 0;
        lat_w  = (net_w >= 170) ? 0 : 170 - net_w;
    end
    a_busy_blocks_ready: assert property (cfg_busy_o |-> !cfg_ready_o)
        else $error("ready shown while busy");
    a_busy_length: assert property ($fell(cfg_busy_o) |->
        busy_q >= RESET_CYCLES && busy_q <= RESET_CYCLES + 2)
        else $error("busy period has wrong length");
    a_ready_follows: assert property (
        $fell(cfg_busy_o) && op_state_o == 3'h3 |-> ##[0:3] cfg_ready_o)
        else $error("ready missing after busy");
    a_counts_clear: assert property (
        $rose(cfg_busy_o) |-> ##[0:2] words_written_o == 8'h00)
        else $error("write count not cleared on reload");
    a_carrier_sum: assert property (live_q |->
        carrier_mhz_o == 12'h960 + 12'(channel_number_o))
        else $error("carrier not base plus channel");
    a_channel_valid: assert property (
        channel_valid_o == (channel_number_o != 7'h00))
        else $error("channel valid flag wrong");
    a_prestart_gate: assert property (
        pll_prestart_en_o == (pll_delay_us_o != 13'h0000))
        else $error("prestart enable wrong");
    a_delay_step: assert property (pll_delay_us_o % 20 == 0)
        else $error("pll delay not a multiple of step");
    a_latency_calc: assert property (live_q |->
        tx_latency_us_o == 8'(pll_prestart_en_o ? lat_w : 170))
        else $error("transmit latency wrong");
    a_fifo_whole: assert property (live_q |->
        fifo_bytes_o != 9'h000 && fifo_bytes_o[1:0] == 2'b00)
        else $error("fifo size not whole words");
    a_written_step: assert property ($changed(words_written_o) |->
        words_written_o == 8'($past(words_written_o) + 1) ||
        words_written_o == 8'h00)
        else $error("write count jumped");
    a_state_legal: assert property (op_state_o <= 3'h4)
        else $error("state code out of range");
    c_reload_done: cover property ($fell(cfg_busy_o));
    c_prestart_on: cover property (pll_prestart_en_o &&
        tx_latency_us_o != 8'haa);
    c_word_taken: cover property ($changed(words_written_o));
endmodule // rbci_config_loader_assertions

bind rbci_config_loader rbci_config_loader_assertions #(
    .RESET_CYCLES(RESET_CYCLES)
) rbci_config_loader_assertions_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_state_o(op_state_o),
    .cfg_ready_o(cfg_ready_o), .cfg_busy_o(cfg_busy_o),
    .channel_number_o(channel_number_o), .channel_valid_o(channel_valid_o),
    .carrier_mhz_o(carrier_mhz_o), .fifo_bytes_o(fifo_bytes_o),
    .pll_prestart_en_o(pll_prestart_en_o), .pll_delay_us_o(pll_delay_us_o),
    .tx_latency_us_o(tx_latency_us_o), .words_written_o(words_written_o)
);

// ==== dv/rbci_host_model.sv ====
// Host controller model: control lines and serial configuration port
`timescale 1ns/1ps
module rbci_host_model #(
    parameter int unsigned GAP_CYCLES = 200
) (
    input  wire logic sys_clk_i,
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      chip_select_o,
    output logic      mode_line_o,
    output logic      power_level_line_o
);
    initial begin
        ser_clk_o          = 1'b0;
        ser_data_o         = 1'b1;
        chip_select_o      = 1'b0;
        mode_line_o        = 1'b1;
        power_level_line_o = 1'b0;
    end
    task automatic lines(input logic pwr, input logic mode, input logic cs);
        @(negedge sys_clk_i);
        power_level_line_o = pwr;
        mode_line_o        = mode;
        chip_select_o      = cs;
    endtask
    // Link clock runs only inside a frame; data moves while it is low
    task automatic shift(input logic [15:0] w, input int n);
        #1.7;
        for (int i = 15; i > 15 - n; i--) begin
            ser_data_o = w[i];
            #3 ser_clk_o = 1'b1;
            #3 ser_clk_o = 1'b0;
        end
        ser_data_o = ~ser_data_o;
    endtask
    task automatic gap();
        lines(1'b1, 1'b0, 1'b0);
        repeat (GAP_CYCLES) @(negedge sys_clk_i);
    endtask
    task automatic send(input logic [15:0] w);
        lines(1'b1, 1'b0, 1'b1);
        repeat (3) @(negedge sys_clk_i);
        shift(w, 16);
        gap();
    endtask
endmodule // rbci_host_model

// ==== dv/testbench.sv ====
// Self-checking bench for the radio configuration loader
`timescale 1ns/1ps
module testbench;
    localparam int unsigned RST_CYC   = 20;
    localparam int unsigned SLEEP_CYC = 50;
    localparam logic [15:0] BASE_W [14] = '{16'h8008, 16'h811b, 16'h8503,
        16'h86b0, 16'h8802, 16'h8e01, 16'h8faa, 16'h8902, 16'h8aaa,
        16'h9401, 16'hac18, 16'hb9b9, 16'hcf66, 16'hf75c};
    localparam logic [15:0] DIR_W [4] = '{16'h8088, 16'h8008, 16'h807f,
        16'h8000};
    logic        sys_clk_i, rst_i, ser_clk, ser_data, cs, mode, pwr;
    logic [2:0]  op_state;
    logic        ready, busy, tx_sel, ch_valid, dest_ins, snd_ins, pre_en;
    logic [6:0]  chan;
    logic [11:0] carrier;
    logic [7:0]  txpwr, addr_b, preamble, latency, written, refused;
    logic [8:0]  fifo_b;
    logic [15:0] local_a, dest_a;
    logic [31:0] tuning;
    logic [12:0] pll_d;
    int          miscompares, tests_run;

    rbci_config_loader #(.RESET_CYCLES(RST_CYC)) rbci_config_loader_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk),
        .ser_data_i(ser_data), .chip_select_i(cs), .mode_line_i(mode),
        .power_level_line_i(pwr), .op_state_o(op_state),
        .cfg_ready_o(ready), .cfg_busy_o(busy), .tx_select_o(tx_sel),
        .channel_number_o(chan), .channel_valid_o(ch_valid),
        .carrier_mhz_o(carrier), .tx_power_crystal_o(txpwr),
        .dest_auto_insert_o(dest_ins), .sender_auto_insert_o(snd_ins),
        .fifo_bytes_o(fifo_b), .addr_bytes_o(addr_b),
        .local_address_o(local_a), .dest_address_o(dest_a),
        .preamble_o(preamble), .tuning_o(tuning),
        .pll_prestart_en_o(pre_en), .pll_delay_us_o(pll_d),
        .tx_latency_us_o(latency), .words_written_o(written),
        .words_refused_o(refused));
    rbci_host_model rbci_host_model_i (.sys_clk_i(sys_clk_i),
        .ser_clk_o(ser_clk), .ser_data_o(ser_data), .chip_select_o(cs),
        .mode_line_o(mode), .power_level_line_o(pwr));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lines(input logic p, input logic m, input logic c);
        rbci_host_model_i.lines(p, m, c);
    endtask
    task automatic send(input logic [15:0] w);
        rbci_host_model_i.send(w);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (n == 200) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic defaults_view();
        chk(preamble, 8'h30);
        chk(tuning, 32'h7c26_bb19);
        chk(txpwr, 8'h00);
        chk(latency, 8'haa);
        chk(local_a, 16'h0000);
        chk(written, 8'h00);
    endtask
    task automatic t_reset_view();
        chk(op_state, 3'h0);
        chk(ready, 1'b0);
        chk(carrier, 12'h960);
        defaults_view();
    endtask
    task automatic t_init();
        lines(1'b0, 1'b1, 1'b0);
        repeat (SLEEP_CYC) @(negedge sys_clk_i);
        lines(1'b1, 1'b0, 1'b1);
        rbci_host_model_i.shift(16'h811b, 16);
        repeat (3) @(negedge sys_clk_i);
        chk(busy, 1'b1);
        wait_ready();
        chk(op_state, 3'h3);
        chk(refused, 8'h01);
        chk(txpwr, 8'h00);
    endtask
    task automatic t_base();
        foreach (BASE_W[i]) send(BASE_W[i]);
        chk({tx_sel, chan}, 8'h08);
        chk(carrier, 12'h968);
        chk(txpwr, 8'h1b);
        chk({fifo_b, snd_ins, dest_ins}, 11'h013);
        chk(addr_b, 8'h02);
        chk({local_a, dest_a}, 32'haa01_aa02);
        chk(preamble, 8'hb0);
        chk(tuning, 32'h5c66_b918);
        chk({pre_en, pll_d}, 14'h2014);
        chk(latency, 8'h87);
        chk(written, 8'h0e);
        chk(op_state, 3'h2);
    endtask
    task automatic t_dir();
        foreach (DIR_W[i]) begin
            send(DIR_W[i]);
            chk(tx_sel, DIR_W[i][7]);
            chk(chan, DIR_W[i][6:0]);
            chk(carrier, 12'h960 + DIR_W[i][6:0]);
            chk(ch_valid, DIR_W[i][6:0] != 7'h00);
        end
    endtask
    task automatic t_refuse();
        logic [7:0] r0, w0;
        r0 = refused;
        w0 = written;
        send(16'h9355);
        send(16'h0177);
        send(16'h9655);
        chk(refused, r0 + 8'h03);
        chk(written, w0);
        chk(txpwr, 8'h1b);
        lines(1'b1, 1'b0, 1'b1);
        rbci_host_model_i.shift(16'h8155, 8);
        rbci_host_model_i.gap();
        send(16'h8124);
        chk(txpwr, 8'h24);
        chk({refused, written}, {r0 + 8'h03, w0 + 8'h01});
    endtask
    task automatic t_modes();
        lines(1'b1, 1'b0, 1'b0);
        repeat (10) @(negedge sys_clk_i);
        chk(op_state, 3'h2);
        lines(1'b1, 1'b1, 1'b0);
        repeat (10) @(negedge sys_clk_i);
        chk(op_state, 3'h4);
        lines(1'b1, 1'b0, 1'b1);
        repeat (30) @(negedge sys_clk_i);
        chk({ready, busy}, 2'b10);
        chk(preamble, 8'hb0);
        lines(1'b0, 1'b1, 1'b0);
        repeat (SLEEP_CYC) @(negedge sys_clk_i);
        chk({op_state, ready}, 4'h0);
        lines(1'b1, 1'b0, 1'b1);
        wait_ready();
        defaults_view();
    endtask
    initial begin
        miscompares = 0;
        tests_run   = 0;
        rst_i       = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        t_reset_view();
        t_init();
        t_base();
        t_dir();
        t_refuse();
        t_modes();
        rst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        t_reset_view();
        stop_test();
    end
endmodule // testbench
